// ### hw/video_port_pkg.sv
package video_port_pkg;
   // register map, byte addresses on the apb bus
   localparam logic [7:0] FORMAT_CTRL_ADDR   = 8'hc8;
   localparam logic [7:0] POLARITY_CFG_ADDR  = 8'hcc;
   localparam logic [7:0] PORT_STATUS_ADDR   = 8'hd0;
   localparam int         ADDR_WIDTH         = 8;

   // reset values and writable masks
   localparam logic [7:0] FORMAT_CTRL_RESET  = 8'h03;
   localparam logic [7:0] FORMAT_CTRL_MASK   = 8'h73;
   localparam logic [7:0] POLARITY_CFG_RESET = 8'h41;
   localparam logic [7:0] POLARITY_CFG_MASK  = 8'hdf;

   // format control fields
   localparam int FMT_LO       = 4;
   localparam int FMT_HI       = 5;
   localparam int INBAND_SAT   = 6;

   // polarity fields
   localparam int POL_EDGE     = 0;
   localparam int POL_LINE     = 1;
   localparam int POL_FRAME    = 2;
   localparam int POL_AUX      = 3;
   localparam int POL_SIGNED   = 4;
   localparam int POL_PIN_SAT  = 6;
   localparam int POL_FORCE_FS = 7;

   // status fields
   localparam int STAT_PHASE   = 0;
   localparam int STAT_LVL_LO  = 8;

   typedef enum logic [1:0] {
      FMT_FULL12  = 2'b00,
      FMT_MSB8    = 2'b01,
      FMT_LO_HI   = 2'b10,
      FMT_HI_LO   = 2'b11
   } fmt_t;

   localparam int         PIX_WIDTH      = 12;
   localparam logic [11:0] FULL_SCALE_U  = 12'hfff;
   localparam logic [11:0] FULL_SCALE_S  = 12'h7ff;
   localparam logic [11:0] UNSIGNED_OFS  = 12'h800;

   // timing
   localparam int CLK_PERIOD_NS  = 8;
   localparam int PIX_PERIOD_NS  = 80;
   localparam int PIX_HALF_CYC   = PIX_PERIOD_NS / (2 * CLK_PERIOD_NS);
   localparam int FIFO_DEPTH     = 8;
endpackage

// ### hw/camera_video_port.sv
// Functional notes
// [R1] format 00: whole 12-bit pixel in one pixel clock cycle
// [R2] format 01: top eight bits in one cycle on low data lines
// [R3] format 10: low byte then high byte, two cycles, low lines
// [R4] format 11: high byte then low byte, two cycles, low lines
// [R5] split formats with in-band option force low byte bit 0 when saturated
// [R6] polarity bit 0 picks launch edge: 0 falling, 1 rising, reset 1
// [R7] polarity bit 1: line sync active high when set, reset 0
// [R8] polarity bit 2: frame sync active high when set, reset 0
// [R9] polarity bit 3: aux sync polarity, only while pin is aux sync
// [R10] polarity bit 4: 0 unsigned offset 2048, 1 two's complement
// [R11] polarity bit 6: shared pin aux sync at 0, saturation flag at 1
// [R12] polarity bit 7: saturated pixels become full scale for the coding
// [R13] unused upper data lines are driven to zero in byte formats
`timescale 1ns/1ps

module pixel_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input  wire logic                       clk,
   input  wire logic                       rst_n,
   input  wire logic                       in_valid,
   output      logic                       in_ready,
   input  wire logic [WIDTH-1:0]           in_data,
   output      logic                       out_valid,
   input  wire logic                       out_ready,
   output      logic [WIDTH-1:0]           out_data,
   output      logic [$clog2(DEPTH):0]     level
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr;
   logic [AW:0]      rd_ptr;
   logic [AW:0]      next_wr_ptr;
   logic [AW:0]      next_rd_ptr;
   logic             push;
   logic             pop;

   always_comb begin
      level       = wr_ptr - rd_ptr;
      in_ready    = (level != DEPTH[AW:0]);
      out_valid   = (level != '0);
      out_data    = mem[rd_ptr[AW-1:0]];
      push        = in_valid && in_ready;
      pop         = out_valid && out_ready;
      next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
      end
   end

   // storage has no reset; empty flag guards reads
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end
endmodule

module camera_video_port
   import video_port_pkg::*;
#(
   parameter int HALF_DIV = PIX_HALF_CYC,
   parameter int DEPTH    = FIFO_DEPTH
) (
   input  wire logic                  clk,
   input  wire logic                  rstn,
   // apb slave
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [ADDR_WIDTH-1:0] paddr,
   input  wire logic [31:0]           pwdata,
   output      logic [31:0]           prdata,
   output      logic                  pready,
   output      logic                  pslverr,
   // pixel stream from the imager core, two's complement distance
   input  wire logic                  pix_valid,
   output      logic                  pix_ready,
   input  wire logic [11:0]           pix_data,
   input  wire logic                  pix_sat,
   input  wire logic                  pix_line,
   input  wire logic                  pix_frame,
   input  wire logic                  pix_aux,
   // parallel video pins
   output      logic                  pixel_clock_out,
   output      logic [11:0]           video_data,
   output      logic                  line_sync_out,
   output      logic                  frame_sync_out,
   output      logic                  aux_sync_out
);
   localparam int FW = PIX_WIDTH + 4;
   localparam int LW = $clog2(DEPTH) + 1;
   localparam int CW = $clog2(HALF_DIV) + 1;

   // reset release through two flops
   logic rst_meta;
   logic rst_n;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // registers
   logic [7:0]  format_ctrl;
   logic [7:0]  polarity_cfg;
   logic [7:0]  next_format_ctrl;
   logic [7:0]  next_polarity_cfg;
   logic [31:0] next_prdata;
   logic        next_pslverr;
   logic        apb_write;
   logic        apb_read;
   logic        phase2;
   logic [LW-1:0] fifo_level;

   always_comb begin
      apb_write         = psel && penable && pwrite;
      apb_read          = psel && !penable && !pwrite;
      next_format_ctrl  = format_ctrl;
      next_polarity_cfg = polarity_cfg;
      next_prdata       = prdata;
      next_pslverr      = 1'b0;
      if (apb_write) begin
         unique case (paddr)
            FORMAT_CTRL_ADDR:
               next_format_ctrl = pwdata[7:0] & FORMAT_CTRL_MASK;
            POLARITY_CFG_ADDR:
               next_polarity_cfg = pwdata[7:0] & POLARITY_CFG_MASK;
            PORT_STATUS_ADDR: ;
            default: ;
         endcase
      end
      // read data is fetched in setup so it stands during access
      if (apb_read) begin
         next_prdata = 32'h0000_0000;
         unique case (paddr)
            FORMAT_CTRL_ADDR:  next_prdata[7:0] = format_ctrl;
            POLARITY_CFG_ADDR: next_prdata[7:0] = polarity_cfg;
            PORT_STATUS_ADDR: begin
               next_prdata[STAT_PHASE] = phase2;
               next_prdata[STAT_LVL_LO +: LW] = fifo_level;
            end
            default: ;
         endcase
      end
      if (psel && !penable) begin
         next_pslverr = !(paddr == FORMAT_CTRL_ADDR ||
                          paddr == POLARITY_CFG_ADDR ||
                          paddr == PORT_STATUS_ADDR);
      end
   end

   assign pready = 1'b1;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         format_ctrl  <= FORMAT_CTRL_RESET;
         polarity_cfg <= POLARITY_CFG_RESET;
         prdata       <= 32'h0000_0000;
         pslverr      <= 1'b0;
      end else begin
         format_ctrl  <= next_format_ctrl;
         polarity_cfg <= next_polarity_cfg;
         prdata       <= next_prdata;
         pslverr      <= next_pslverr;
      end
   end

   // pixel buffer; a full buffer stalls the imager core
   logic          fifo_valid;
   logic          fifo_pop;
   logic [FW-1:0] fifo_word;

   pixel_fifo #(
      .WIDTH (FW),
      .DEPTH (DEPTH)
   ) i_pixel_fifo (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_valid  (pix_valid),
      .in_ready  (pix_ready),
      .in_data   ({pix_aux, pix_frame, pix_line, pix_sat, pix_data}),
      .out_valid (fifo_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_word),
      .level     (fifo_level)
   );

   // pixel clock divider, the link clock is made here
   logic [CW-1:0] div_cnt;
   logic [CW-1:0] next_div_cnt;
   logic          next_pclk;
   logic          wrap;
   logic          launch;

   always_comb begin
      wrap         = (div_cnt == CW'(HALF_DIV - 1));
      next_div_cnt = wrap ? '0 : div_cnt + 1'b1;
      next_pclk    = wrap ? !pixel_clock_out : pixel_clock_out;
      // launch on the edge that takes the clock to the selected level
      launch = wrap && (pixel_clock_out != polarity_cfg[POL_EDGE]); // [R6]
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_cnt         <= '0;
         pixel_clock_out <= 1'b0;
      end else begin
         div_cnt         <= next_div_cnt;
         pixel_clock_out <= next_pclk;
      end
   end

   // beat formatting
   logic [11:0] coded;
   logic [11:0] value;
   logic [7:0]  low_byte;
   logic        w_sat;
   logic        w_line;
   logic        w_frame;
   logic        w_aux;
   logic        signed_mode;
   fmt_t        fmt;
   logic [7:0]  hold;
   logic [7:0]  next_hold;
   logic        next_phase2;
   logic [11:0] next_video_data;
   logic        next_line;
   logic        next_frame;
   logic        next_aux;
   logic        sat_now;
   logic        next_sat_now;
   logic        line_now;
   logic        frame_now;
   logic        aux_now;

   always_comb begin
      {w_aux, w_frame, w_line, w_sat} = fifo_word[FW-1:PIX_WIDTH];
      signed_mode = polarity_cfg[POL_SIGNED];
      fmt         = fmt_t'(format_ctrl[FMT_HI:FMT_LO]);
      // offset binary is the signed value with the top bit flipped
      coded = signed_mode ? fifo_word[11:0]
                          : fifo_word[11:0] ^ UNSIGNED_OFS; // [R10]
      value = coded;
      if (w_sat && polarity_cfg[POL_FORCE_FS]) begin
         value = signed_mode ? FULL_SCALE_S : FULL_SCALE_U; // [R12]
      end
      low_byte = value[7:0];
      if (w_sat && format_ctrl[INBAND_SAT]) begin
         low_byte[0] = 1'b1; // [R5]
      end

      fifo_pop        = 1'b0;
      next_phase2     = phase2;
      next_hold       = hold;
      next_video_data = video_data;
      next_line       = line_now;
      next_frame      = frame_now;
      next_aux        = aux_now;
      next_sat_now    = sat_now;

      if (launch) begin
         if (phase2) begin
            next_video_data = {4'h0, hold}; // [R3] [R4] [R13]
            next_phase2     = 1'b0;
         end else if (fifo_valid) begin
            fifo_pop     = 1'b1;
            next_line    = w_line;
            next_frame   = w_frame;
            next_aux     = w_aux;
            next_sat_now = w_sat;
            unique case (fmt)
               FMT_FULL12: next_video_data = value; // [R1]
               FMT_MSB8:   next_video_data = {4'h0, value[11:4]}; // [R2] [R13]
               FMT_LO_HI: begin
                  next_video_data = {4'h0, low_byte}; // [R3] [R13]
                  next_hold       = {4'h0, value[11:8]};
                  next_phase2     = 1'b1;
               end
               FMT_HI_LO: begin
                  next_video_data = {8'h00, value[11:8]}; // [R4] [R13]
                  next_hold       = low_byte;
                  next_phase2     = 1'b1;
               end
            endcase
         end else begin
            // empty buffer: idle beat with syncs inactive
            next_video_data = 12'h000;
            next_line       = 1'b0;
            next_frame      = 1'b0;
            next_aux        = 1'b0;
            next_sat_now    = 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phase2     <= 1'b0;
         hold       <= 8'h00;
         video_data <= 12'h000;
         line_now   <= 1'b0;
         frame_now  <= 1'b0;
         aux_now    <= 1'b0;
         sat_now    <= 1'b0;
      end else begin
         phase2     <= next_phase2;
         hold       <= next_hold;
         video_data <= next_video_data;
         line_now   <= next_line;
         frame_now  <= next_frame;
         aux_now    <= next_aux;
         sat_now    <= next_sat_now;
      end
   end

   // pin levels follow the launch edge so polarity changes stay glitch free
   logic next_line_pin;
   logic next_frame_pin;
   logic next_aux_pin;

   always_comb begin
      next_line_pin  = line_sync_out;
      next_frame_pin = frame_sync_out;
      next_aux_pin   = aux_sync_out;
      if (launch) begin
         next_line_pin  = next_line ~^ polarity_cfg[POL_LINE]; // [R7]
         next_frame_pin = next_frame ~^ polarity_cfg[POL_FRAME]; // [R8]
         if (polarity_cfg[POL_PIN_SAT]) begin
            next_aux_pin = next_sat_now; // [R11]
         end else begin
            next_aux_pin = next_aux ~^ polarity_cfg[POL_AUX]; // [R9] [R11]
         end
      end
   end

   // reset values match the reset polarity settings (syncs low active idle)
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         line_sync_out  <= 1'b1;
         frame_sync_out <= 1'b1;
         aux_sync_out   <= 1'b0;
      end else begin
         line_sync_out  <= next_line_pin;
         frame_sync_out <= next_frame_pin;
         aux_sync_out   <= next_aux_pin;
      end
   end
endmodule

// ### verification/camera_video_port_props.sv
`timescale 1ns/1ps
module camera_video_port_props
   import video_port_pkg::*;
#(
   parameter int HALF_DIV = PIX_HALF_CYC
) (
   input wire logic                  clk,
   input wire logic                  rstn,
   input wire logic                  psel,
   input wire logic                  penable,
   input wire logic                  pwrite,
   input wire logic [ADDR_WIDTH-1:0] paddr,
   input wire logic [31:0]           pwdata,
   input wire logic [31:0]           prdata,
   input wire logic                  pready,
   input wire logic                  pslverr,
   input wire logic                  pix_ready,
   input wire logic                  pixel_clock_out,
   input wire logic [11:0]           video_data,
   input wire logic                  line_sync_out
);
   // shadows follow apb writes, so no internal probes are needed
   logic [7:0] pol, fmt, next_pol, next_fmt;
   logic       pck_q, seen, next_seen, acc, mapped, tog, rd;
   int         cnt, next_cnt;
   assign acc    = psel && penable;
   assign rd     = acc && !pwrite;
   assign mapped = paddr == FORMAT_CTRL_ADDR || paddr == POLARITY_CFG_ADDR
                   || paddr == PORT_STATUS_ADDR;
   assign tog    = pixel_clock_out != pck_q;
   always_comb begin
      next_pol  = pol;
      next_fmt  = fmt;
      if (acc && pwrite && paddr == POLARITY_CFG_ADDR)
         next_pol = pwdata[7:0] & POLARITY_CFG_MASK;
      if (acc && pwrite && paddr == FORMAT_CTRL_ADDR)
         next_fmt = pwdata[7:0] & FORMAT_CTRL_MASK;
      next_cnt  = tog ? 0 : cnt + 1;
      // first toggle after reset is not timed: divider phase is free
      next_seen = seen || tog;
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pol   <= POLARITY_CFG_RESET;
         fmt   <= FORMAT_CTRL_RESET;
         pck_q <= 1'b0;
         cnt   <= 0;
         seen  <= 1'b0;
      end else begin
         pol   <= next_pol;
         fmt   <= next_fmt;
         pck_q <= pixel_clock_out;
         cnt   <= next_cnt;
         seen  <= next_seen;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   property p_launch;
      $changed(video_data) |-> tog && pixel_clock_out == pol[POL_EDGE];
   endproperty
   a_launch: assert property (p_launch)
      else $error("data moved off the launch edge");
   property p_line;
      $changed(line_sync_out) |-> tog && pixel_clock_out == pol[POL_EDGE];
   endproperty
   a_line: assert property (p_line)
      else $error("line sync moved off the launch edge");
   property p_upper;
      fmt[FMT_HI:FMT_LO] != 2'b00 |-> video_data[11:8] == 4'h0;
   endproperty
   a_upper: assert property (p_upper)
      else $error("upper data lines not zero in byte format");
   property p_half;
      tog && seen |-> cnt == HALF_DIV - 1;
   endproperty
   a_half: assert property (p_half)
      else $error("pixel clock half period wrong");
   property p_pready;
      acc |-> pready;
   endproperty
   a_pready: assert property (p_pready)
      else $error("apb access without ready");
   property p_err;
      acc |-> pslverr == !mapped;
   endproperty
   a_err: assert property (p_err)
      else $error("apb error flag wrong");
   property p_rd_pol;
      rd && paddr == POLARITY_CFG_ADDR |-> prdata == {24'h0, pol};
   endproperty
   a_rd_pol: assert property (p_rd_pol)
      else $error("polarity readback wrong");
   property p_rd_fmt;
      rd && paddr == FORMAT_CTRL_ADDR |-> prdata == {24'h0, fmt};
   endproperty
   a_rd_fmt: assert property (p_rd_fmt)
      else $error("format readback wrong");
   property p_rd_bad;
      rd && !mapped |-> prdata == 32'h0;
   endproperty
   a_rd_bad: assert property (p_rd_bad)
      else $error("unmapped read not zero");
   c_bad: cover property (acc && !mapped);
   c_full: cover property (!pix_ready);
   c_split: cover property (fmt[FMT_HI] && $changed(video_data));
endmodule
bind camera_video_port camera_video_port_props #(.HALF_DIV(HALF_DIV))
   i_camera_video_port_props (.clk(clk), .rstn(rstn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .pix_ready(pix_ready), .pixel_clock_out(pixel_clock_out),
   .video_data(video_data), .line_sync_out(line_sync_out));

// ### verification/video_capture_model.sv
`timescale 1ns/1ps
module video_capture_model
   import video_port_pkg::*;
(
   input wire logic        clk,
   input wire logic [7:0]  pol,
   input wire logic        pixel_clock_out,
   input wire logic [11:0] video_data,
   input wire logic        line_sync_out,
   input wire logic        frame_sync_out,
   input wire logic        aux_sync_out
);
   logic [13:0] beats[$];
   logic        pck_q = 1'b0;
   // capture half a period after launch, where the pins are settled
   always @(posedge clk) begin
      pck_q <= pixel_clock_out;
      if (pixel_clock_out != pck_q && pixel_clock_out != pol[POL_EDGE]
          && line_sync_out == pol[POL_LINE])
         beats.push_back({frame_sync_out, aux_sync_out, video_data});
   end
endmodule

// ### verification/camera_video_port_tb.sv
`timescale 1ns/1ps
module camera_video_port_tb;
   import video_port_pkg::*;
   logic        clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, pix_valid = 1'b0, pix_sat = 1'b0;
   logic        pix_aux = 1'b0, saw_full = 1'b0;
   logic        pix_line = 1'b0, pix_frame = 1'b0;
   logic [7:0]  paddr = 8'h00, pol_m = 8'h41;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [11:0] pix_data = 12'h000, vdata;
   logic        pready, pslverr, pix_ready, pck, lsync, fsync, async_pin;
   int          n_mismatch = 0;
   int          check_count = 0;
   always #4 clk = ~clk;
   camera_video_port #(.HALF_DIV(5), .DEPTH(8)) i_camera_video_port (
      .clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pix_valid(pix_valid),
      .pix_ready(pix_ready), .pix_data(pix_data), .pix_sat(pix_sat),
      .pix_line(pix_line), .pix_frame(pix_frame), .pix_aux(pix_aux),
      .pixel_clock_out(pck), .video_data(vdata), .line_sync_out(lsync),
      .frame_sync_out(fsync), .aux_sync_out(async_pin));
   video_capture_model i_video_capture_model (.clk(clk), .pol(pol_m),
      .pixel_clock_out(pck), .video_data(vdata), .line_sync_out(lsync),
      .frame_sync_out(fsync), .aux_sync_out(async_pin));
   task automatic check(input string what, input logic [31:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // one idle cycle after each transfer keeps a signal from two writes
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   function automatic logic [11:0] pix(input int i);
      return 12'h0a5 + 12'(i) * 12'h1d3;
   endfunction
   task automatic run(input logic [1:0] f, input logic ib,
                      input logic [7:0] p);
      logic [31:0] r;
      logic        e, s;
      logic [11:0] v, lo;
      logic [1:0]  h;
      logic [13:0] x[$];
      int          n;
      apb(1'b1, FORMAT_CTRL_ADDR, {25'h0, ib, f, 4'h3}, r, e);
      apb(1'b1, POLARITY_CFG_ADDR, {24'h0, p}, r, e);
      // model switches polarity first so no stale beat lands after the purge
      pol_m <= p;
      repeat (20) @(posedge clk);
      i_video_capture_model.beats.delete();
      pix_valid <= 1'b1;
      for (int i = 0; i < 12; i++) begin
         pix_data <= pix(i);
         pix_sat <= i % 3 == 1;
         pix_aux <= i[0];
         pix_line <= i != 11;
         pix_frame <= i > 1;
         do begin
            @(posedge clk);
            if (pix_ready !== 1'b1) saw_full = 1'b1;
         end while (pix_ready !== 1'b1);
      end
      pix_valid <= 1'b0;
      repeat (300) @(posedge clk);
      for (int i = 0; i < 12; i++) begin
         // pixel 11 is outside the line, so the model never captures it
         if (i == 11) continue;
         s = i % 3 == 1;
         v = p[7] && s ? (p[4] ? 12'h7ff : 12'hfff)
                       : (p[4] ? pix(i) : pix(i) ^ 12'h800);
         h = {(i > 1) ~^ p[2], p[6] ? s : (i[0] ~^ p[3])};
         lo = {4'h0, v[7:1], v[0] | (ib & s)};
         case (f)
            2'b00: x.push_back({h, v});
            2'b01: x.push_back({h, 4'h0, v[11:4]});
            2'b10: begin
               x.push_back({h, lo});
               x.push_back({h, 8'h0, v[11:8]});
            end
            default: begin
               x.push_back({h, 8'h0, v[11:8]});
               x.push_back({h, lo});
            end
         endcase
      end
      n = i_video_capture_model.beats.size();
      check("beat count", n, x.size());
      foreach (x[k])
         if (k < n)
            check("beat", i_video_capture_model.beats[k], x[k]);
      $display("test format %0d polarity %h done", f, p);
   endtask
   initial begin
      logic [31:0] r;
      logic        e;
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      apb(1'b0, POLARITY_CFG_ADDR, 32'h0, r, e);
      check("polarity reset", r, 32'h41);
      apb(1'b0, FORMAT_CTRL_ADDR, 32'h0, r, e);
      check("format reset", r, 32'h03);
      apb(1'b0, PORT_STATUS_ADDR, 32'h0, r, e);
      check("status idle", r, 32'h0);
      apb(1'b1, 8'h80, 32'hff, r, e);
      check("unmapped write error", e, 1'b1);
      apb(1'b0, 8'h80, 32'h0, r, e);
      check("unmapped read", {r[30:0], e}, 32'h1);
      apb(1'b1, POLARITY_CFG_ADDR, 32'hff, r, e);
      apb(1'b0, POLARITY_CFG_ADDR, 32'h0, r, e);
      check("polarity mask", r, 32'hdf);
      $display("test registers done");
      run(2'b00, 1'b1, 8'h41);
      run(2'b01, 1'b0, 8'h1e);
      run(2'b10, 1'b1, 8'hc1);
      run(2'b11, 1'b1, 8'h90);
      check("fifo refused", saw_full, 1'b1);
      stop_test();
   end
   // four runs need about 13 us, so 100 us means a hang
   initial begin
      #100000;
      n_mismatch++;
      stop_test();
   end
endmodule
